// ===== logic/app_block_regs.svh
/*
  constants for the application block/unblock command handler: command
  bytes, status words, data length and write cycle count.
  assumes inclusion by bare name from the design and bench modules.
*/
`ifndef APP_BLOCK_REGS_SVH
`define APP_BLOCK_REGS_SVH
`define CLA_SM_A 8'h8C
`define CLA_SM_B 8'h84
`define INS_APP_BLOCK 8'h1E
`define INS_APP_UNBLOCK 8'h18
`define INS_SELECT 8'hA4
`define INS_GEN_AC 8'hAE
`define INS_EXT_AUTH 8'h82
`define INS_INT_AUTH 8'h88
`define CLA_INTERINDUSTRY 8'h00
`define CLA_PROPRIETARY 8'h80
`define PARAM_UNUSED 8'h00
`define SW_OK 16'h9000
`define SW_WARN_NO_INFO 16'h6200
`define SW_WARN_CORRUPT 16'h6281
`define SW_FILE_INVALID 16'h6283
`define SW_NVM_UNCHANGED 16'h6400
`define SW_MEM_FAILURE 16'h6581
`define SW_SEC_NOT_MET 16'h6982
`define SW_REF_INVALID 16'h6984
`define SW_SM_MISSING 16'h6987
`define SW_SM_WRONG 16'h6988
`define SW_BAD_P1P2 16'h6A86
`define SW_REF_NOT_FOUND 16'h6A88
`define SW_INS_UNSUPPORTED 16'h6D00
`define CRYPT_DECLINE 2'h0
`define NO_DATA 8'h00
`define WRITE_CYCLES 4'h3
`endif

// ===== logic/app_block_pkg.sv
/*
  types shared by both ends of the block/unblock command link.
  assumes app_block_regs.svh is on the include path.
*/
package app_block_pkg;
  // cryptogram kinds: decline, referral, online request, approval
  typedef enum logic [1:0] {
    decline_cryptogram,
    referral_cryptogram,
    online_cryptogram,
    approval_cryptogram
  } crypt_kind_type;
  // sm object check outcome supplied by the secure messaging unit
  typedef enum logic [1:0] {
    sm_good,
    sm_missing,
    sm_wrong
  } sm_result_type;
endpackage

// ===== logic/apdu_link_if.sv
/*
  command/response link between terminal end and card end.
  assumes one clock shared by both ends; one command outstanding.
*/
`timescale 1ns/100ps
interface apdu_link_if
  import app_block_pkg::*;
  ();
  logic cmd_valid;
  logic [7:0] cla;
  logic [7:0] ins;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] lc;
  sm_result_type sm_result;
  crypt_kind_type crypt_req;
  logic rsp_valid;
  logic [15:0] sw;
  logic [7:0] rsp_len;
  crypt_kind_type crypt_rsp;
  modport card (
    input cmd_valid, cla, ins, p1, p2, lc, sm_result, crypt_req,
    output rsp_valid, sw, rsp_len, crypt_rsp
  );
  modport terminal (
    output cmd_valid, cla, ins, p1, p2, lc, sm_result, crypt_req,
    input rsp_valid, sw, rsp_len, crypt_rsp
  );
endinterface

// ===== logic/invalid_flag_store.sv
/*
  persistent invalidated flag of the selected application with a
  modelled write time; write failures are injected from outside.
  assumes the real cell keeps its value over card reset: i_reset does
  not touch the stored bit, only the write sequencer.
*/
`timescale 1ns/100ps
`include "app_block_regs.svh"
module invalid_flag_store
  import app_block_pkg::*;
  (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset, sequencer only
  input wire logic i_write, // start write, pulse
  input wire logic i_value, // value to store
  input wire logic i_fail, // make this write fail
  output logic o_busy, // write in progress
  output logic o_done, // write finished, pulse
  output logic o_ok, // last write succeeded
  output logic o_flag // stored invalidated flag
  );
  typedef struct packed {
    logic flag;
    logic busy;
    logic done;
    logic ok;
    logic fail;
    logic value;
    logic [3:0] count;
  } store_state_type;
  store_state_type s_q, s_d;
  logic flag_init_q = 1'b0;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!flag_init_q) begin
      s_d.flag = 1'b0;
    end
    if (i_reset) begin
      s_d.busy = 1'b0;
      s_d.ok = 1'b1;
      s_d.count = 4'h0;
    end else if (!s_q.busy && i_write) begin
      s_d.busy = 1'b1;
      s_d.fail = i_fail;
      s_d.value = i_value;
      s_d.count = `WRITE_CYCLES;
    end else if (s_q.busy) begin
      if (s_q.count == 4'h0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.ok = !s_q.fail;
        // a failed write leaves the cell unchanged
        if (!s_q.fail) begin
          s_d.flag = s_q.value; // RULE23
        end
      end else begin
        s_d.count = s_q.count - 4'h1;
      end
    end
  end
  // the cell has no reset; a one-time init flag stands in for the
  // factory-erased state so simulation starts from a known value
  always_ff @(posedge i_clk) begin
    s_q <= s_d;
    flag_init_q <= 1'b1;
  end
  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_ok = s_q.ok;
  assign o_flag = s_q.flag;
endmodule

// ===== logic/app_card_end.sv
/*
  card end: decodes block, unblock, select, generate-cryptogram and
  both authenticate commands, keeps the invalidated flag and answers.
  assumes the transport layer presents one whole command header with
  the secure messaging check result and waits for rsp_valid.
  status word and cryptogram kind are staged while a command runs and
  move to the link only with rsp_valid or i_reset, which loads 9000 and decline,
  so they stand until the next answer or reset. the invalidated flag itself lives in the store and is not
  touched by i_reset; o_invalidated trails it by one cycle.
  a command offered while busy is ignored; the terminal must wait for
  the answer.
*/
// Notes on behaviour
// RULE1: reserved bits and bytes are sent as zero
// RULE2: only basic channel; one application active
// RULE3: terminal sends these only in scripts, secured
// RULE4: block sets invalidated until unblock succeeds
// RULE5: select of invalidated application answers 6283
// RULE6: invalidated application returns decline cryptogram only
// RULE7: authenticate on invalidated application answers 6984
// RULE8: block is CLA 8C/84, INS 1E, P1P2 zero
// RULE9: unblock is CLA 8C/84, INS 18, P1P2 zero
// RULE10: nonzero P1 or P2 answers 6A86
// RULE11: data is MAC component, checked first; here P1/P2 are checked before it (6A86)
// RULE12: block/unblock answer status bytes only
// RULE13: successful block answers 9000 even if already
// RULE14: successful unblock answers 9000 regardless of state
// RULE15: unblock lifts all invalidation effects
// RULE16: block may warn 6200, 6281, 6283
// RULE17: failed update answers 6400 or 6581
// RULE18: unblock may warn 6581 too
// RULE19: unmet security conditions answer 6982
// RULE20: missing object 6987, wrong object 6988
// RULE21: missing key 6A88; may answer 6984
// RULE22: unused parameter bytes are sent as 00
// RULE23: invalidated flag kept in nonvolatile storage
`timescale 1ns/100ps
`include "app_block_regs.svh"
module app_card_end
  import app_block_pkg::*;
  (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset, active high
  apdu_link_if.card link, // command link from terminal
  input wire logic i_sec_ok, // security conditions met
  input wire logic i_key_found, // referenced key present
  input wire logic i_key_valid, // referenced key not invalidated
  input wire logic i_nvm_fail, // inject write failure
  input wire logic i_nvm_changed, // failed write disturbed memory
  input wire logic [1:0] i_warn_sel, // optional warning on success
  output logic o_invalidated, // application invalidated
  output logic o_busy // command in progress
  );
  typedef enum logic [1:0] {
    st_idle,
    st_write,
    st_answer
  } card_state_type;
  typedef struct packed {
    card_state_type state;
    logic is_block;
    logic rsp_valid;
    logic [15:0] sw;
    crypt_kind_type crypt;
    logic invalidated;
    logic busy;
    logic [7:0] rsp_len;
    logic [15:0] out_sw;
    crypt_kind_type out_crypt;
  } card_reg_type;
  card_reg_type r_q, r_d;
  logic nvm_write, nvm_busy, nvm_done, nvm_ok, nvm_flag;
  logic cla_sm, p_zero, hit_block, hit_unblock;
  logic [15:0] chk_sw;
  // the store keeps its cell over reset; only its sequencer is cleared
  invalid_flag_store u_store (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_write(nvm_write),
    .i_value(r_q.is_block),
    .i_fail(i_nvm_fail),
    .o_busy(nvm_busy),
    .o_done(nvm_done),
    .o_ok(nvm_ok),
    .o_flag(nvm_flag)
  );
  // channel bits of CLA are fixed, so only channel 0 is ever accepted
  assign cla_sm = (link.cla == `CLA_SM_A) || (link.cla == `CLA_SM_B); // RULE2
  assign p_zero = (link.p1 == `PARAM_UNUSED) && (link.p2 == `PARAM_UNUSED);
  assign hit_block = cla_sm && (link.ins == `INS_APP_BLOCK); // RULE8
  assign hit_unblock = cla_sm && (link.ins == `INS_APP_UNBLOCK); // RULE9
  // check order: parameters, then sm object, then security, then key
  // a missing key outranks an invalidated one
  always_comb begin
    chk_sw = `SW_OK;
    if (!p_zero) begin
      chk_sw = `SW_BAD_P1P2; // RULE10
    end else if (link.sm_result == sm_missing) begin
      chk_sw = `SW_SM_MISSING; // RULE20
    end else if (link.sm_result == sm_wrong) begin
      chk_sw = `SW_SM_WRONG; // RULE11
    end else if (!i_sec_ok) begin
      chk_sw = `SW_SEC_NOT_MET; // RULE19
    end else if (!i_key_found) begin
      chk_sw = `SW_REF_NOT_FOUND; // RULE21
    end else if (!i_key_valid) begin
      chk_sw = `SW_REF_INVALID; // RULE21
    end
  end
  always_comb begin
    r_d = r_q;
    r_d.rsp_valid = 1'b0;
    r_d.rsp_len = `NO_DATA; // RULE12 RULE1
    r_d.invalidated = nvm_flag;
    nvm_write = 1'b0;
    unique case (r_q.state)
      st_idle: begin
        r_d.busy = 1'b0;
        // other commands answer from the stored flag alone
        if (link.cmd_valid) begin
          r_d.busy = 1'b1;
          r_d.state = st_answer;
          r_d.crypt = decline_cryptogram;
          r_d.sw = `SW_OK;
          if (hit_block || hit_unblock) begin
            r_d.is_block = hit_block;
            r_d.sw = chk_sw;
            if (chk_sw == `SW_OK) begin
              r_d.state = st_write;
            end
          end else if (link.ins == `INS_SELECT &&
                       link.cla == `CLA_INTERINDUSTRY) begin
            if (nvm_flag) begin
              r_d.sw = `SW_FILE_INVALID; // RULE5
            end
          end else if (link.ins == `INS_GEN_AC &&
                       link.cla == `CLA_PROPRIETARY) begin
            r_d.crypt = nvm_flag ? decline_cryptogram // RULE6
                                 : link.crypt_req;
          end else if ((link.ins == `INS_EXT_AUTH ||
                        link.ins == `INS_INT_AUTH) &&
                       link.cla == `CLA_INTERINDUSTRY) begin
            if (nvm_flag) begin
              r_d.sw = `SW_REF_INVALID; // RULE7
            end
          end else begin
            r_d.sw = `SW_INS_UNSUPPORTED;
          end
        end
      end
      st_write: begin
        // cmd_valid is not looked at here: one command at a time
        // write is issued even if flag already holds the value
        nvm_write = !nvm_busy && !nvm_done;
        if (nvm_done) begin
          r_d.state = st_answer;
          if (!nvm_ok) begin
            r_d.sw = i_nvm_changed ? `SW_MEM_FAILURE // RULE17
                                   : `SW_NVM_UNCHANGED;
          end else if (r_q.is_block) begin
            unique case (i_warn_sel) // RULE16
              2'h1: r_d.sw = `SW_WARN_NO_INFO;
              2'h2: r_d.sw = `SW_WARN_CORRUPT;
              2'h3: r_d.sw = `SW_FILE_INVALID;
              default: r_d.sw = `SW_OK; // RULE13 RULE4
            endcase
          end else begin
            unique case (i_warn_sel) // RULE18
              2'h1: r_d.sw = `SW_WARN_NO_INFO;
              2'h2: r_d.sw = `SW_WARN_CORRUPT;
              2'h3: r_d.sw = `SW_MEM_FAILURE;
              default: r_d.sw = `SW_OK; // RULE14 RULE15
            endcase
          end
        end
      end
      st_answer: begin
        // staged answer goes out together with its strobe
        r_d.rsp_valid = 1'b1;
        r_d.out_sw = r_q.sw;
        r_d.out_crypt = r_q.crypt;
        r_d.state = st_idle;
      end
      default: begin
        // unused state code: drop back to idle rather than hang
        r_d.state = st_idle;
        r_d.busy = 1'b0;
      end
    endcase
    if (i_reset) begin
      r_d.state = st_idle;
      r_d.rsp_valid = 1'b0;
      r_d.sw = `SW_OK;
      r_d.crypt = decline_cryptogram;
      r_d.is_block = 1'b0;
      r_d.out_sw = `SW_OK;
      r_d.out_crypt = decline_cryptogram;
      r_d.busy = 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    r_q <= r_d;
  end
  // every link output is a register bit, so the far end sees no glitches
  assign link.rsp_valid = r_q.rsp_valid;
  assign link.sw = r_q.out_sw;
  assign link.rsp_len = r_q.rsp_len; // RULE12 RULE1
  assign link.crypt_rsp = r_q.out_crypt;
  assign o_invalidated = r_q.invalidated;
  assign o_busy = r_q.busy;
endmodule

// ===== logic/app_terminal_end.sv
/*
  terminal end: sends one command on request and reports the answer.
  assumes the user raises i_go only while o_idle is high and supplies
  block/unblock only within script processing.
*/
`timescale 1ns/100ps
`include "app_block_regs.svh"
module app_terminal_end
  import app_block_pkg::*;
  (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset, active high
  apdu_link_if.terminal link, // command link to card
  input wire logic i_go, // send command, pulse
  input wire logic [7:0] i_cla, // class byte
  input wire logic [7:0] i_ins, // instruction byte
  input wire logic [7:0] i_p1, // parameter 1
  input wire logic [7:0] i_p2, // parameter 2
  input wire logic [7:0] i_lc, // data length
  input wire logic i_script, // inside issuer script processing
  input wire sm_result_type i_sm, // sm object outcome
  input wire crypt_kind_type i_crypt, // requested cryptogram
  output logic o_idle, // ready for a command
  output logic o_done, // answer arrived, pulse
  output logic [15:0] o_sw, // status word of answer
  output crypt_kind_type o_crypt // cryptogram kind answered
  );
  typedef struct packed {
    logic cmd_valid;
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
    sm_result_type sm;
    crypt_kind_type crypt_req;
    logic waiting;
    logic idle;
    logic done;
    logic [15:0] sw;
    crypt_kind_type crypt;
  } term_reg_type;
  term_reg_type t_q, t_d;
  logic post_issue;
  assign post_issue = (i_ins == `INS_APP_BLOCK) ||
                      (i_ins == `INS_APP_UNBLOCK);
  always_comb begin
    t_d = t_q;
    t_d.cmd_valid = 1'b0;
    t_d.done = 1'b0;
    // post-issuance commands outside a script are dropped here
    if (i_go && !t_q.waiting && (!post_issue || i_script)) begin // RULE3
      t_d.cmd_valid = 1'b1;
      t_d.waiting = 1'b1;
      t_d.ins = i_ins;
      t_d.lc = i_lc;
      t_d.sm = i_sm;
      t_d.crypt_req = i_crypt;
      t_d.cla = post_issue ? `CLA_SM_A : i_cla; // RULE3 RULE8 RULE9
      t_d.p1 = post_issue ? `PARAM_UNUSED : i_p1; // RULE22 RULE1
      t_d.p2 = post_issue ? `PARAM_UNUSED : i_p2; // RULE22
    end
    if (t_q.waiting && link.rsp_valid) begin
      t_d.waiting = 1'b0;
      t_d.done = 1'b1;
      t_d.sw = link.sw;
      t_d.crypt = link.crypt_rsp;
    end
    if (i_reset) begin
      t_d = '0;
      t_d.sw = `SW_OK;
    end
    t_d.idle = !t_d.waiting;
  end
  always_ff @(posedge i_clk) begin
    t_q <= t_d;
  end
  assign link.cmd_valid = t_q.cmd_valid;
  assign link.cla = t_q.cla;
  assign link.ins = t_q.ins;
  assign link.p1 = t_q.p1;
  assign link.p2 = t_q.p2;
  assign link.lc = t_q.lc;
  assign link.sm_result = t_q.sm;
  assign link.crypt_req = t_q.crypt_req;
  assign o_idle = t_q.idle;
  assign o_done = t_q.done;
  assign o_sw = t_q.sw;
  assign o_crypt = t_q.crypt;
endmodule

// ===== sim/app_block_link_sva.sv
/*
  checker for one block/unblock command link.
  assumes the link signals and the clock and reset shared by both ends.
*/
`timescale 1ns/100ps
`include "app_block_regs.svh"
module app_block_link_sva
  import app_block_pkg::*;
  (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic cmd_valid, // command pulse
  input wire logic [7:0] cla, // class byte
  input wire logic [7:0] ins, // instruction byte
  input wire logic [7:0] p1, // parameter 1
  input wire logic [7:0] p2, // parameter 2
  input wire logic [7:0] lc, // data length
  input wire sm_result_type sm_result, // sm outcome
  input wire crypt_kind_type crypt_req, // requested kind
  input wire logic rsp_valid, // answer pulse
  input wire logic [15:0] sw, // status word
  input wire logic [7:0] rsp_len, // answer data length
  input wire crypt_kind_type crypt_rsp // answered kind
  );
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic blk;
  logic ic;
  assign blk = cmd_valid && (cla == `CLA_SM_A || cla == `CLA_SM_B) &&
    (ins == `INS_APP_BLOCK || ins == `INS_APP_UNBLOCK);
  assign ic = cmd_valid && cla == `CLA_INTERINDUSTRY;
  chk_rsp_no_data: assert property (rsp_valid |-> rsp_len == `NO_DATA)
    else $error("answer carries data bytes");
  chk_unused_zero: assert property (blk |-> p1 == 8'h00 && p2 == 8'h00)
    else $error("unused parameter byte not zero");
  chk_sm_missing: assert property (blk && sm_result == sm_missing
    |-> ##2 rsp_valid && sw == `SW_SM_MISSING)
    else $error("missing object not answered 6987");
  chk_sm_wrong: assert property (blk && sm_result == sm_wrong
    |-> ##2 rsp_valid && sw == `SW_SM_WRONG)
    else $error("wrong object not answered 6988");
  chk_write_answer: assert property (blk |-> ##[2:16] rsp_valid)
    else $error("block or unblock left unanswered");
  chk_sw_hold: assert property (!rsp_valid && !$past(i_reset) |-> $stable(sw))
    else $error("status word moved without an answer");
  chk_unknown_ins: assert property (cmd_valid && !(ins inside
    {8'h1E, 8'h18, 8'hA4, 8'hAE, 8'h82, 8'h88})
    |-> ##2 rsp_valid && sw == `SW_INS_UNSUPPORTED)
    else $error("unknown instruction not answered 6D00");
  chk_auth_status: assert property (ic && ins inside {8'h82, 8'h88}
    |-> ##2 rsp_valid && sw inside {`SW_OK, `SW_REF_INVALID})
    else $error("authenticate answered with a wrong status");
  chk_select_status: assert property (ic && ins == `INS_SELECT
    |-> ##2 rsp_valid && sw inside {`SW_OK, `SW_FILE_INVALID})
    else $error("select answered with a wrong status");
  chk_decline_kept: assert property (cmd_valid && ins == `INS_GEN_AC &&
    crypt_req == decline_cryptogram |-> ##2 crypt_rsp == decline_cryptogram)
    else $error("decline request not answered with decline");
  cover property (blk ##[2:16] rsp_valid && sw == `SW_OK);
  cover property (rsp_valid && sw == `SW_FILE_INVALID);
  cover property (rsp_valid && sw == `SW_REF_INVALID);
endmodule

// ===== sim/app_block_unblock_cmd_handler_tb_top.sv
/*
  bench: terminal and card ends on one link, plus a second card end fed
  by the bench with headers the terminal end would never send.
  assumes the design files and app_block_regs.svh on the include path.
*/
`timescale 1ns/100ps
`include "app_block_regs.svh"
module app_block_unblock_cmd_handler_tb_top
  import app_block_pkg::*;
  ;
  typedef struct {logic [15:0] sw; logic chk; crypt_kind_type cr;} exp_type;
  exp_type exp_q[$];
  exp_type x;
  logic [15:0] sw_b_q[$];
  logic i_clk = 0, i_reset = 1, i_go = 0, i_script = 1, i_sec_ok = 1;
  logic i_key_found = 1, i_key_valid = 1, i_nvm_fail = 0, i_nvm_changed = 0;
  logic [1:0] i_warn_sel = 0;
  logic [7:0] i_cla = 0, i_ins = 0, i_p1 = 0, i_p2 = 0, i_lc = 0;
  sm_result_type i_sm = sm_good;
  crypt_kind_type i_crypt = decline_cryptogram, o_crypt;
  logic o_idle, o_done, o_invalidated, o_busy, inv_b;
  logic [15:0] o_sw, rnd = 16'h3CB1;
  int err_count = 0, comparisons = 0, cyc = 0;
  logic [15:0] fsw [5] = '{`SW_SM_MISSING, `SW_SM_WRONG, `SW_SEC_NOT_MET,
    `SW_REF_NOT_FOUND, `SW_REF_INVALID};
  logic [15:0] wblk [4] = '{16'h9000, 16'h6200, 16'h6281, 16'h6283};
  logic [15:0] wunb [4] = '{16'h9000, 16'h6200, 16'h6281, 16'h6581};
  apdu_link_if i_apdu_link_if ();
  apdu_link_if i_apdu_link_if_b ();
  app_terminal_end i_app_terminal_end (.i_clk, .i_reset,
    .link(i_apdu_link_if.terminal), .i_go, .i_cla, .i_ins, .i_p1, .i_p2,
    .i_lc, .i_script, .i_sm, .i_crypt, .o_idle, .o_done, .o_sw, .o_crypt);
  app_card_end i_app_card_end (.i_clk, .i_reset,
    .link(i_apdu_link_if.card), .i_sec_ok, .i_key_found, .i_key_valid,
    .i_nvm_fail, .i_nvm_changed, .i_warn_sel, .o_invalidated, .o_busy);
  app_card_end i_app_card_end_b (.i_clk, .i_reset,
    .link(i_apdu_link_if_b.card), .i_sec_ok, .i_key_found, .i_key_valid,
    .i_nvm_fail, .i_nvm_changed, .i_warn_sel, .o_invalidated(inv_b),
    .o_busy());
  app_block_link_sva i_app_block_link_sva (.i_clk, .i_reset,
    .cmd_valid(i_apdu_link_if.cmd_valid), .cla(i_apdu_link_if.cla),
    .ins(i_apdu_link_if.ins), .p1(i_apdu_link_if.p1),
    .p2(i_apdu_link_if.p2), .lc(i_apdu_link_if.lc),
    .sm_result(i_apdu_link_if.sm_result),
    .crypt_req(i_apdu_link_if.crypt_req),
    .rsp_valid(i_apdu_link_if.rsp_valid), .sw(i_apdu_link_if.sw),
    .rsp_len(i_apdu_link_if.rsp_len),
    .crypt_rsp(i_apdu_link_if.crypt_rsp));
  always #5 i_clk = ~i_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic cmp_sw(input logic [15:0] g, e);
    check(g === e, $sformatf("status %h, expected %h", g, e));
  endtask
  task automatic cmp_cr(input crypt_kind_type g, e);
    check(g === e, "cryptogram kind");
  endtask
  task automatic cmp_bit(input logic g, e);
    check(g === e, "level output");
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // parameter bytes of block/unblock get noise: the terminal must clear them
  task automatic send(input logic [7:0] c, n, input logic [15:0] e,
    input crypt_kind_type k = decline_cryptogram);
    int w;
    w = 0;
    @(negedge i_clk);
    rnd = lfsr(rnd);
    {i_go, i_cla, i_ins, i_lc} = {1'b1, c, n, rnd[7:0]};
    i_crypt = k;
    {i_p1, i_p2} = (n == `INS_APP_BLOCK || n == `INS_APP_UNBLOCK) ? rnd :
      16'h0000;
    exp_q.push_back('{e, n == `INS_GEN_AC, decline_cryptogram});
    @(negedge i_clk);
    i_go = 0;
    while (o_done !== 1'b1 && w < 50) begin
      @(negedge i_clk);
      w++;
    end
    check(w < 50, "no answer");
    $display("test %h %h ended", c, n);
  endtask
  task automatic direct(input logic [7:0] c, n, a, b, input logic [15:0] e);
    int w;
    w = 0;
    sw_b_q.push_back(e);
    {i_apdu_link_if_b.cmd_valid, i_apdu_link_if_b.cla, i_apdu_link_if_b.ins,
      i_apdu_link_if_b.p1, i_apdu_link_if_b.p2} = {1'b1, c, n, a, b};
    @(negedge i_clk);
    i_apdu_link_if_b.cmd_valid = 0;
    while (i_apdu_link_if_b.rsp_valid !== 1'b1 && w < 50) begin
      @(negedge i_clk);
      w++;
    end
    check(w < 50, "no answer on second link");
    $display("test %h %h ended on second link", c, n);
    @(negedge i_clk);
  endtask
  always @(negedge i_clk) begin
    if (o_done === 1'b1) begin
      x = exp_q.pop_front();
      cmp_sw(o_sw, x.sw);
      cmp_bit(o_busy, 1'b0);
      if (x.chk)
        cmp_cr(o_crypt, x.cr);
    end
    if (i_apdu_link_if.rsp_valid === 1'b1)
      cmp_bit(o_busy, 1'b1);
    if (i_apdu_link_if_b.rsp_valid === 1'b1)
      cmp_sw(i_apdu_link_if_b.sw, sw_b_q.pop_front());
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      check(1'b0, "run took too long");
      finish_test;
    end
  end
  initial begin
    {i_apdu_link_if_b.cmd_valid, i_apdu_link_if_b.lc} = 0;
    i_apdu_link_if_b.sm_result = sm_good;
    i_apdu_link_if_b.crypt_req = decline_cryptogram;
    repeat (3) @(negedge i_clk);
    i_reset = 0;
    send(`CLA_INTERINDUSTRY, `INS_SELECT, `SW_OK);
    for (int f = 0; f < 5; f++) begin
      i_sm = f == 0 ? sm_missing : f == 1 ? sm_wrong : sm_good;
      i_sec_ok = f != 2;
      i_key_found = f != 3;
      i_key_valid = f != 4;
      send(`CLA_SM_A, f[0] ? 8'h18 : 8'h1E, fsw[f]);
    end
    i_key_valid = 1;
    cmp_bit(o_invalidated, 1'b0);
    repeat (2) send(`CLA_SM_A, `INS_APP_BLOCK, `SW_OK);
    cmp_bit(o_invalidated, 1'b1);
    for (int k = 0; k < 4; k++)
      send(`CLA_PROPRIETARY, `INS_GEN_AC, `SW_OK, crypt_kind_type'(k));
    for (int a = 0; a < 2; a++)
      send(`CLA_INTERINDUSTRY, a ? 8'h88 : 8'h82, `SW_REF_INVALID);
    for (int v = 1; v < 4; v++) begin
      i_warn_sel = v[1:0];
      send(`CLA_SM_A, `INS_APP_BLOCK, wblk[v]);
    end
    i_warn_sel = 0;
    // the flag lives in nonvolatile cells, so a reset must not clear it
    i_reset = 1;
    repeat (3) @(negedge i_clk);
    i_reset = 0;
    send(`CLA_INTERINDUSTRY, `INS_SELECT, `SW_FILE_INVALID);
    i_nvm_fail = 1;
    for (int m = 0; m < 2; m++) begin
      i_nvm_changed = m[0];
      send(`CLA_SM_A, 8'h18, m ? `SW_MEM_FAILURE : `SW_NVM_UNCHANGED);
    end
    i_nvm_fail = 0;
    cmp_bit(o_invalidated, 1'b1);
    for (int v = 1; v < 4; v++) begin
      i_warn_sel = v[1:0];
      send(`CLA_SM_A, `INS_APP_UNBLOCK, wunb[v]);
    end
    i_warn_sel = 0;
    cmp_bit(o_invalidated, 1'b0);
    send(`CLA_SM_A, `INS_APP_UNBLOCK, `SW_OK);
    // outside a script the terminal swallows the command: no answer
    i_script = 0;
    @(negedge i_clk);
    {i_go, i_cla, i_ins} = {1'b1, `CLA_SM_A, `INS_APP_BLOCK};
    @(negedge i_clk);
    i_go = 0;
    repeat (12) begin
      @(negedge i_clk);
      cmp_bit(o_done || !o_idle || o_busy, 1'b0);
    end
    i_script = 1;
    cmp_bit(o_invalidated, 1'b0);
    send(`CLA_INTERINDUSTRY, `INS_SELECT, `SW_OK);
    for (int a = 0; a < 2; a++)
      send(`CLA_INTERINDUSTRY, a ? 8'h88 : 8'h82, `SW_OK);
    send(`CLA_PROPRIETARY, 8'hCA, `SW_INS_UNSUPPORTED);
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      direct(j[0] ? 8'h84 : 8'h8C, j[1] ? 8'h18 : 8'h1E,
        j[0] ? 8'h00 : rnd[7:0] | 8'h01, j[0] ? rnd[15:8] | 8'h01 : 8'h00,
        `SW_BAD_P1P2);
    end
    cmp_bit(inv_b, 1'b0);
    direct(`CLA_SM_B, `INS_APP_BLOCK, 8'h00, 8'h00, `SW_OK);
    cmp_bit(inv_b, 1'b1);
    finish_test;
  end
endmodule
